// ---- verilog/wut_defines.svh ----
// Constants for the wake-up timer: widths, select codes, timing counts.
// Assumes a 100 MHz system clock and one power-on reset for the block.
//
// Operation
// (RULE1) 24-bit down counter with 24-bit reload value
// (RULE2) Reload writable only in INIT, NORMAL, WAKE
// (RULE3) Tick is 100 kHz or 100 Hz, selectable
// (RULE4) Fast base: 10 us steps, up to 168 s
// (RULE5) Slow base: 10 ms steps, up to 1.9 days
// (RULE6) Low-power entry loads counter, then decrements per tick
// (RULE7) Underflow issues wake request from SLEEP or STANDBY
// (RULE8) Leaving SLEEP raises an interrupt
// (RULE9) Counting starts at most 40 us after entry
// (RULE10) Extra latency stays under 50 us
// (RULE11) Inactive in power-down and initialisation states
// (RULE12) Idle outside low power; each entry restarts count
`ifndef WUT_DEFINES_SVH
`define WUT_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define WUT_CNT_W 24
`define WUT_BYTE_W 8
`define WUT_DLY_W 11
`define WUT_DIV_W 20

// ----------------------------------------------------------------
// Configuration write selects
// ----------------------------------------------------------------
`define WUT_SEL_LOW 2'h0
`define WUT_SEL_MID 2'h1
`define WUT_SEL_HIGH 2'h2
`define WUT_SEL_BASE 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WUT_CLK_NS 10
`define WUT_FAST_TICK_NS 10000
`define WUT_SLOW_TICK_NS 10000000
`define WUT_ACT_DLY_NS 20000
`define WUT_FAST_DIV (`WUT_FAST_TICK_NS / `WUT_CLK_NS)
`define WUT_SLOW_DIV (`WUT_SLOW_TICK_NS / `WUT_CLK_NS)
`define WUT_ACT_CYC (`WUT_ACT_DLY_NS / `WUT_CLK_NS)

`endif

// ---- verilog/wut_pkg.sv ----
// Types for the wake-up timer.
// Assumes the state machine encodes device states as below.
`default_nettype none

package wut_pkg;

    typedef enum logic [2:0] {
        DEV_POWERDOWN = 3'b000,
        DEV_INIT = 3'b001,
        DEV_NORMAL = 3'b010,
        DEV_SLEEP = 3'b011,
        DEV_STANDBY = 3'b100,
        DEV_WAKE = 3'b101,
        DEV_FAILSAFE = 3'b110
    } wut_dev_state_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ARM = 2'b01,
        PH_COUNT = 2'b10,
        PH_DONE = 2'b11
    } wut_phase_t;

    typedef struct packed {
        wut_phase_t phase;
        logic [23:0] reload;
        logic slow;
        logic [23:0] count;
        logic [10:0] dly;
        wut_dev_state_t prev_state;
        logic wake;
        logic irq;
        logic reject;
        logic running;
    } wut_state_t;

    typedef struct packed {
        logic [19:0] cnt;
        logic tick;
    } wut_tick_state_t;

endpackage : wut_pkg

`default_nettype wire

// ---- verilog/wut_tick_gen.sv ----
// Time-base tick generator: one-cycle tick every FAST_DIV or SLOW_DIV clocks.
// Assumes run comes from a flop on the same clock; restarts whenever run drops.
`default_nettype none
`include "wut_defines.svh"

module wut_tick_gen #(
    parameter int unsigned SLOW_DIV = `WUT_SLOW_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic slow,
    output logic tick
);
    import wut_pkg::*;

    wut_tick_state_t st;
    wut_tick_state_t next_st;
    logic [`WUT_DIV_W-1:0] last;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    always_comb begin
        last = slow ? `WUT_DIV_W'(SLOW_DIV - 1) : `WUT_DIV_W'(`WUT_FAST_DIV - 1); // RULE3
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.cnt = '0;
        end else if (st.cnt == last) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1; // RULE4 RULE5
        end else begin
            next_st.cnt = st.cnt + `WUT_DIV_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : wut_tick_gen

`default_nettype wire

// ---- verilog/wut_top.sv ----
// Wake-up timer: reload storage, arming delay, 24-bit down count, wake and
// interrupt pulses. Assumes STATE_IN and the write port come from logic on
// CLK_SYS_IN, and RST_IN is the device power-on reset.
`default_nettype none
`include "wut_defines.svh"

module wut_top #(
    parameter int unsigned SLOW_DIV = `WUT_SLOW_DIV
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire wut_pkg::wut_dev_state_t STATE_IN,
    input wire logic WR_EN_IN,
    input wire logic [1:0] WR_SEL_IN,
    input wire logic [7:0] WR_DATA_IN,
    output logic WAKE_REQ_OUT,
    output logic INT_REQ_OUT,
    output logic WR_REJECT_OUT,
    output logic RUNNING_OUT,
    output logic TIMEBASE_SLOW_OUT,
    output logic [23:0] RELOAD_OUT,
    output logic [23:0] COUNT_OUT
);
    import wut_pkg::*;

    wut_state_t st;
    wut_state_t next_st;
    logic tick;
    logic low_power;
    logic entry;
    logic cfg_open;

    // ----------------------------------------------------------------
    // State decode
    // ----------------------------------------------------------------
    always_comb begin
        low_power = (STATE_IN == DEV_SLEEP) || (STATE_IN == DEV_STANDBY);
        // Sleep to standby directly still counts as a fresh entry
        entry = low_power && (STATE_IN != st.prev_state); // RULE12
        cfg_open = (STATE_IN == DEV_INIT) || (STATE_IN == DEV_NORMAL)
            || (STATE_IN == DEV_WAKE); // RULE2
    end

    // ----------------------------------------------------------------
    // Tick source
    // ----------------------------------------------------------------
    wut_tick_gen #(
        .SLOW_DIV(SLOW_DIV)
    ) u_tick (
        .clk(CLK_SYS_IN),
        .rst(RST_IN),
        .ce(CE_IN),
        .run(st.phase == PH_COUNT),
        .slow(st.slow),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wake = 1'b0;
        next_st.irq = 1'b0;
        next_st.reject = 1'b0;
        next_st.prev_state = STATE_IN;

        // Writes outside the open states are dropped, not queued
        if (WR_EN_IN) begin
            if (cfg_open) begin // RULE2
                case (WR_SEL_IN)
                    `WUT_SEL_LOW: begin
                        next_st.reload[7:0] = WR_DATA_IN; // RULE1
                    end
                    `WUT_SEL_MID: begin
                        next_st.reload[15:8] = WR_DATA_IN; // RULE1
                    end
                    `WUT_SEL_HIGH: begin
                        next_st.reload[23:16] = WR_DATA_IN; // RULE1
                    end
                    default: begin
                        next_st.slow = WR_DATA_IN[0]; // RULE3
                    end
                endcase
            end else begin
                next_st.reject = 1'b1;
            end
        end

        if ((st.prev_state == DEV_SLEEP) && (STATE_IN != DEV_SLEEP)) begin
            next_st.irq = 1'b1; // RULE8
        end

        if (!low_power) begin
            next_st.phase = PH_IDLE; // RULE11 RULE12
            next_st.dly = '0;
        end else if (entry) begin
            next_st.phase = PH_ARM; // RULE6
            next_st.count = st.reload; // RULE6
            next_st.dly = '0;
        end else begin
            case (st.phase)
                PH_ARM: begin
                    // Fixed arming wait keeps start well inside the 40 us bound
                    if (st.dly == `WUT_DLY_W'(`WUT_ACT_CYC - 1)) begin
                        next_st.phase = PH_COUNT; // RULE9
                    end else begin
                        next_st.dly = st.dly + `WUT_DLY_W'(1);
                    end
                end
                PH_COUNT: begin
                    if (tick) begin
                        if (st.count == '0) begin
                            next_st.wake = 1'b1; // RULE7 RULE10
                            next_st.phase = PH_DONE;
                        end else begin
                            next_st.count = st.count - `WUT_CNT_W'(1); // RULE1 RULE6
                        end
                    end
                end
                PH_DONE: begin
                    // One wake per entry; waits for the state to change
                    next_st.phase = PH_DONE;
                end
                default: begin
                    next_st.phase = PH_IDLE;
                end
            endcase
        end
        // Own flop so the status pin carries no decode glitch
        next_st.running = (next_st.phase == PH_COUNT);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            st <= '0;
        end else if (CE_IN) begin
            st <= next_st;
        end
    end

    assign WAKE_REQ_OUT = st.wake;
    assign INT_REQ_OUT = st.irq;
    assign WR_REJECT_OUT = st.reject;
    assign RUNNING_OUT = st.running;
    assign TIMEBASE_SLOW_OUT = st.slow;
    assign RELOAD_OUT = st.reload;
    assign COUNT_OUT = st.count;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);

    int arm_cycles;
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN || st.phase != PH_ARM) begin
            arm_cycles <= 0;
        end else if (CE_IN) begin
            arm_cycles <= arm_cycles + 1;
        end
    end

    a_write_closed: assert property ( // RULE2
        (CE_IN && WR_EN_IN && !cfg_open) |=> ($stable(RELOAD_OUT) && WR_REJECT_OUT)
    ) else $error("reload changed while configuration is closed");

    a_write_open: assert property ( // RULE1
        (CE_IN && WR_EN_IN && cfg_open && WR_SEL_IN == `WUT_SEL_HIGH)
            |=> (RELOAD_OUT[23:16] == $past(WR_DATA_IN))
    ) else $error("high reload byte not stored");

    a_entry_load: assert property ( // RULE6
        (CE_IN && entry) |=> (COUNT_OUT == $past(RELOAD_OUT) && st.phase == PH_ARM)
    ) else $error("counter not loaded on low-power entry");

    a_arm_bound: assert property ( // RULE9
        (st.phase == PH_ARM) |-> (arm_cycles < `WUT_ACT_CYC)
    ) else $error("arming delay too long");

    a_count_step: assert property ( // RULE1
        (CE_IN && RUNNING_OUT && tick && COUNT_OUT != '0 && low_power && !entry)
            |=> (COUNT_OUT == $past(COUNT_OUT) - `WUT_CNT_W'(1))
    ) else $error("counter did not decrement on tick");

    a_hold_no_tick: assert property ( // RULE6
        (CE_IN && RUNNING_OUT && !tick && low_power && !entry) |=> $stable(COUNT_OUT)
    ) else $error("counter moved without a tick");

    a_wake_cause: assert property ( // RULE7
        WAKE_REQ_OUT |-> $past(RUNNING_OUT && tick && COUNT_OUT == '0 && low_power)
    ) else $error("wake request without underflow");

    a_idle_off: assert property ( // RULE11
        (CE_IN && (STATE_IN == DEV_POWERDOWN || STATE_IN == DEV_INIT))
            |=> !RUNNING_OUT && !WAKE_REQ_OUT
    ) else $error("timer active in power-down or init");

    a_sleep_irq: assert property ( // RULE8
        (CE_IN && st.prev_state == DEV_SLEEP && STATE_IN != DEV_SLEEP) |=> INT_REQ_OUT
    ) else $error("no interrupt on leaving sleep");

    a_irq_cause: assert property ( // RULE8
        INT_REQ_OUT |-> $past(st.prev_state == DEV_SLEEP && STATE_IN != DEV_SLEEP)
    ) else $error("interrupt without leaving sleep");

    c_wake_fast: cover property (WAKE_REQ_OUT && !TIMEBASE_SLOW_OUT);
    c_wake_slow: cover property (WAKE_REQ_OUT && TIMEBASE_SLOW_OUT);
    c_reentry: cover property (RUNNING_OUT ##1 entry);
    c_reject: cover property (WR_REJECT_OUT);

endmodule : wut_top

`default_nettype wire

// ---- test/wut_mcu_model.sv ----
// Controller model: drives the timer's config write port and device state.
// Assumes the bench calls its tasks; all changes land by NBA at rising edges.
`default_nettype none

module wut_mcu_model
    import wut_pkg::*;
(
    input wire logic clk,
    input wire logic wr_reject,
    output wut_dev_state_t state,
    output logic wr_en,
    output logic [1:0] wr_sel,
    output logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----
    // Port driving
    // ----
    initial begin
        state = DEV_INIT;
        wr_en = 1'b0;
        wr_sel = 2'h0;
        wr_data = 8'h00;
    end

    // One-cycle strobe; released data inverted so stale bytes never look valid
    task automatic write_byte(input logic [1:0] sel, input logic [7:0] data,
                              output logic rej);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= sel;
        wr_data <= data;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~data;
        #1;
        rej = wr_reject;
    endtask : write_byte

    // Caller keeps the state in INIT, NORMAL or WAKE while programming
    task automatic write_value(input logic [23:0] v, input logic slow);
        logic r;
        write_byte(2'h0, v[7:0], r);
        write_byte(2'h1, v[15:8], r);
        write_byte(2'h2, v[23:16], r);
        write_byte(2'h3, {7'h00, slow}, r);
    endtask : write_value

    task automatic set_state(input wut_dev_state_t s);
        @(posedge clk);
        state <= s;
    endtask : set_state

endmodule : wut_mcu_model

`default_nettype wire

// ---- test/tb_wake_up_timer.sv ----
// Testbench for the wake-up timer: config writes, refusals, wake timing, interrupt.
// Assumes the design takes SLOW_DIV from its parameter; fast base is 1000 clocks.
`default_nettype none

module tb_wake_up_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import wut_pkg::*;

    localparam int SLOW_DIV = 50;
    localparam int FAST_DIV = 1000;
    localparam int ACT_MAX = 4000;
    localparam int LAT_MAX = 5000;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    wut_dev_state_t state;
    logic wr_en, wr_reject, wake, irq, running, slow_base;
    logic [1:0] wr_sel;
    logic [7:0] wr_data;
    logic [23:0] reload, count;
    int fail_count = 0;
    int total_checks = 0;

    wut_mcu_model i_mcu (.clk(clk), .wr_reject(wr_reject), .state(state),
        .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data));

    wut_top #(.SLOW_DIV(SLOW_DIV)) i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .STATE_IN(state), .WR_EN_IN(wr_en), .WR_SEL_IN(wr_sel), .WR_DATA_IN(wr_data),
        .WAKE_REQ_OUT(wake), .INT_REQ_OUT(irq), .WR_REJECT_OUT(wr_reject),
        .RUNNING_OUT(running), .TIMEBASE_SLOW_OUT(slow_base), .RELOAD_OUT(reload),
        .COUNT_OUT(count));

    // ----
    // Helpers
    // ----
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----
    // Scenarios
    // ----
    task automatic test_writes;
        logic r;
        logic [7:0] last;
        i_mcu.set_state(DEV_NORMAL);
        i_mcu.write_value(24'h5A3CC3, 1'b0);
        check(reload, 24'h5A3CC3);
        last = 8'hC3;
        for (int s = 0; s < 7; s++) begin
            i_mcu.set_state(wut_dev_state_t'(s[2:0]));
            i_mcu.write_byte(2'h0, 8'h10 + s[7:0], r);
            if (s == 1 || s == 2 || s == 5) begin
                last = 8'h10 + s[7:0];
            end
            check(r, !(s == 1 || s == 2 || s == 5));
            check(reload, {16'h5A3C, last});
        end
        i_mcu.set_state(DEV_NORMAL);
        $display("test_writes done");
    endtask : test_writes

    task automatic test_timer(input logic sl, input logic [23:0] n,
                              input wut_dev_state_t lp);
        int run_c, wake_c, lo;
        run_c = -1;
        wake_c = -1;
        lo = (n + 1) * (sl ? SLOW_DIV : FAST_DIV);
        i_mcu.write_value(n, sl);
        check(slow_base, sl);
        i_mcu.set_state(lp);
        @(posedge clk);
        #1;
        check(count, n);
        for (int i = 1; i < lo + ACT_MAX + LAT_MAX + 10 && wake_c < 0; i++) begin
            @(posedge clk);
            #1;
            if (running === 1'b1 && run_c < 0) begin
                run_c = i;
            end
            if (wake === 1'b1) begin
                wake_c = i;
            end
        end
        check(run_c >= 0 && run_c <= ACT_MAX, 1'b1);
        check(wake_c >= lo && wake_c <= lo + ACT_MAX + LAT_MAX, 1'b1);
        check((wake_c - run_c) >= lo && (wake_c - run_c) <= lo + 2, 1'b1);
        i_mcu.set_state(DEV_NORMAL);
        @(posedge clk);
        #1;
        check(irq, lp == DEV_SLEEP);
        $display("test_timer base %0d n %0d wake at %0d", sl, n, wake_c);
    endtask : test_timer

    task automatic test_idle_restart;
        int seen;
        seen = 0;
        i_mcu.write_value(24'h000002, 1'b1);
        i_mcu.set_state(DEV_INIT);
        repeat (3000) begin
            @(posedge clk);
            #1;
            seen += (wake !== 1'b0 || running !== 1'b0);
        end
        check(seen, 0);
        i_mcu.set_state(DEV_SLEEP);
        for (int i = 0; i < ACT_MAX && count !== 24'h000001; i++) begin
            @(posedge clk);
            #1;
        end
        check(count, 24'h000001);
        // Enable low for longer than a slow tick: nothing may move
        @(posedge clk);
        ce <= 1'b0;
        repeat (120) @(posedge clk);
        #1;
        check(count, 24'h000001);
        check(running, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        i_mcu.set_state(DEV_STANDBY);
        @(posedge clk);
        #1;
        check(count, 24'h000002);
        check(running, 1'b0);
        i_mcu.set_state(DEV_NORMAL);
        $display("test_idle_restart done");
    endtask : test_idle_restart

    // ----
    // Sequence and watchdog
    // ----
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({wake, irq, wr_reject, running, slow_base}, 24'h0);
        check(reload, 24'h0);
        $display("test_reset done");
        test_writes();
        test_timer(1'b1, 24'h000000, DEV_SLEEP);
        test_timer(1'b1, 24'h000003, DEV_STANDBY);
        test_timer(1'b0, 24'h000001, DEV_SLEEP);
        test_idle_restart();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        tally_and_finish();
    end

endmodule : tb_wake_up_timer

`default_nettype wire
